//--- counter_array_mode_ctrl.sv
// mode, watchdog and interrupt gating control for the counter array
`timescale 1ns/1ns
module counter_array_mode_ctrl
(
	input  wire logic                                    CLK,
	input  wire logic                                    ARST_N,
	input  wire logic [counter_array_pkg::SFR_AW-1:0]    SFR_ADDR,
	input  wire logic                                    SFR_WR,
	input  wire logic [counter_array_pkg::SFR_DW-1:0]    SFR_WDATA,
	output logic      [counter_array_pkg::SFR_DW-1:0]    SFR_RDATA,
	input  wire logic                                    CPU_IDLE,
	input  wire logic                                    TIMER0_OVF,
	input  wire logic                                    EXTERNAL_COUNT_INPUT,
	input  wire logic                                    EXT_CLK,
	input  wire logic                                    GLOBAL_IRQ_ENABLE,
	input  wire logic                                    ARRAY_IRQ_ENABLE,
	input  wire logic                                    COUNTER_OVERFLOW_FLAG,
	input  wire logic [counter_array_pkg::MODULES-1:0]   MODULE_MATCH_FLAG,
	output logic                                         COUNT_TICK,
	output logic [counter_array_pkg::MODULES*3-1:0]      MODULE_OPMODE,
	output logic                                         WATCHDOG_ACTIVE,
	output logic                                         WATCHDOG_EXPIRE,
	output logic                                         IRQ_REQ
);
	import counter_array_pkg::*;

	logic [7:0]         array_mode;
	logic [7:0]         module_mode_register [MODULES];
	logic               mode_wr;
	logic               idle_suspend;
	logic               watchdog_enable;
	logic               watchdog_lock;
	logic [2:0]         timebase_select;
	logic               overflow_irq_enable;
	logic               tb_tick;
	logic [MODULES-1:0] match_enable;
	logic [MODULES-1:0] match_route;
	logic               next_irq;
	logic [7:0]         next_rdata;
	logic [3:0]         div12_age;

	// mode field to operating mode, reserved code turns module off
	function automatic logic [2:0] decode_mode(input logic [7:0] cfg);
		logic [2:0] field;
		field = cfg[MODULE_FIELD_LO +: MODE_W];
		decode_mode = (field > OPMODE_PWM16) ? OPMODE_OFF : field;
	endfunction

	function automatic logic is_module_addr(input logic [7:0] a);
		is_module_addr = (a >= ADDR_MODULE_BASE) && (a <= ADDR_MODULE_LAST);
	endfunction

	assign mode_wr = SFR_WR && (SFR_ADDR == ADDR_ARRAY_MODE);
	assign idle_suspend = array_mode[IDLE_SUSPEND_BIT];
	assign watchdog_enable = array_mode[WATCHDOG_ENABLE_BIT];
	assign watchdog_lock = array_mode[WATCHDOG_LOCK_BIT];
	assign timebase_select = array_mode[TIMEBASE_LO +: 3];
	assign overflow_irq_enable = array_mode[OVERFLOW_IRQ_ENABLE_BIT];

	// ************************************************************
	// array mode register
	// ************************************************************
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			array_mode <= ARRAY_MODE_RESET;
		else if (mode_wr)
		begin
			if (watchdog_enable)
			begin
				// only the watchdog bits respond while it runs
				// a locked watchdog cannot be turned off
				if (!watchdog_lock && !SFR_WDATA[WATCHDOG_ENABLE_BIT])
					array_mode[WATCHDOG_ENABLE_BIT] <= 1'b0;
				if (SFR_WDATA[WATCHDOG_LOCK_BIT])
					array_mode[WATCHDOG_LOCK_BIT] <= 1'b1;
			end
			else
			begin
				array_mode <= (SFR_WDATA & ARRAY_MODE_WMASK)
					| {2'h0, watchdog_lock, 5'h00};
			end
		end
	end

	// ************************************************************
	// module mode registers
	// ************************************************************
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			for (int i = 0; i < MODULES; i++)
				module_mode_register[i] <= MODULE_MODE_RESET;
		end
		else if (SFR_WR && is_module_addr(SFR_ADDR))
			module_mode_register[3'(SFR_ADDR - ADDR_MODULE_BASE)] <=
				SFR_WDATA & MODULE_MODE_WMASK;
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			MODULE_OPMODE <= '0;
		else
		begin
			// each module decoded on its own
			for (int i = 0; i < MODULES; i++)
				MODULE_OPMODE[i*3 +: 3] <= decode_mode(module_mode_register[i]);
		end
	end

	// ************************************************************
	// register read back
	// ************************************************************
	always_comb
	begin
		next_rdata = 8'h00;
		if (SFR_ADDR == ADDR_ARRAY_MODE)
			next_rdata = array_mode & ARRAY_MODE_WMASK;
		else if (is_module_addr(SFR_ADDR))
			next_rdata = module_mode_register[3'(SFR_ADDR - ADDR_MODULE_BASE)];
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			SFR_RDATA <= 8'h00;
		else
			SFR_RDATA <= next_rdata;
	end

	// ************************************************************
	// timebase and idle suspension
	// ************************************************************
	// reserved codes are left to software to avoid; they stall here
	counter_array_timebase counter_array_timebase_i
	(
		.clk          (CLK),
		.arst_n       (ARST_N),
		.sel          (timebase_select),
		.timer0_ovf   (TIMER0_OVF),
		.ext_count_in (EXTERNAL_COUNT_INPUT),
		.ext_clk      (EXT_CLK),
		.tick         (tb_tick)
	);

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			COUNT_TICK <= 1'b0;
		else
			COUNT_TICK <= tb_tick && !(idle_suspend && CPU_IDLE);
	end

	// ************************************************************
	// watchdog and interrupt request
	// ************************************************************
	always_comb
	begin
		for (int i = 0; i < MODULES; i++)
			match_enable[i] = module_mode_register[i][MODULE_MATCH_IRQ_ENABLE_BIT];
		// while the watchdog is enabled, module 5 match feeds it, not the interrupt
		match_route = MODULE_MATCH_FLAG & match_enable;
		if (watchdog_enable)
			match_route[WATCHDOG_MODULE] = 1'b0;
		next_irq = GLOBAL_IRQ_ENABLE && ARRAY_IRQ_ENABLE
			&& ((overflow_irq_enable && COUNTER_OVERFLOW_FLAG) || |match_route);
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			WATCHDOG_ACTIVE <= 1'b0;
			WATCHDOG_EXPIRE <= 1'b0;
		end
		else
		begin
			WATCHDOG_ACTIVE <= watchdog_enable;
			WATCHDOG_EXPIRE <= watchdog_enable
				&& MODULE_MATCH_FLAG[WATCHDOG_MODULE];
		end
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			IRQ_REQ <= 1'b0;
		else
			IRQ_REQ <= next_irq;
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	locked_write_a: assert property (
		(mode_wr && watchdog_enable) |=>
			(array_mode[4:0] == $past(array_mode[4:0]))
			&& (idle_suspend == $past(idle_suspend)))
		else $error("mode register changed while watchdog ran");

	lock_holds_a: assert property (
		(watchdog_lock && watchdog_enable) |=> watchdog_enable)
		else $error("locked watchdog was disabled");

	lock_sticky_a: assert property (
		watchdog_lock |=> watchdog_lock)
		else $error("watchdog lock cleared without reset");

	idle_stop_a: assert property (
		(idle_suspend && CPU_IDLE) |=> !COUNT_TICK)
		else $error("counter ticked while suspended in idle");

	idle_run_a: assert property (
		(tb_tick && !idle_suspend) |=> COUNT_TICK)
		else $error("tick lost while running");

	irq_gate_a: assert property (
		IRQ_REQ |-> $past(GLOBAL_IRQ_ENABLE) && $past(ARRAY_IRQ_ENABLE))
		else $error("interrupt raised with gating off");

	module_irq_a: assert property (
		(GLOBAL_IRQ_ENABLE && ARRAY_IRQ_ENABLE && MODULE_MATCH_FLAG[0]
			&& module_mode_register[0][MODULE_MATCH_IRQ_ENABLE_BIT])
			|=> IRQ_REQ)
		else $error("enabled module match gave no interrupt");

	ovf_irq_a: assert property (
		(GLOBAL_IRQ_ENABLE && ARRAY_IRQ_ENABLE && COUNTER_OVERFLOW_FLAG
			&& overflow_irq_enable) |=> IRQ_REQ)
		else $error("enabled overflow gave no interrupt");

	wdt_route_a: assert property (
		(watchdog_enable && MODULE_MATCH_FLAG[WATCHDOG_MODULE])
			|=> WATCHDOG_EXPIRE ##1 WATCHDOG_ACTIVE || !watchdog_enable)
		else $error("module 5 match missed the watchdog");

	// cycles the /12 source has stood selected; a switch of source
	// must not look like an early tick
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			div12_age <= 4'h0;
		else if (timebase_select != TB_SYS_DIV12)
			div12_age <= 4'h0;
		else if (div12_age != 4'hF)
			div12_age <= div12_age + 4'h1;
	end

	div12_gap_a: assert property (
		(tb_tick && div12_age == 4'hF)
			|=> (!tb_tick || div12_age == 4'h0) [*8])
		else $error("divide by 12 tick came too soon");

endmodule

//--- counter_array_mode_ctrl_bench.sv
// self-checking bench for the counter array mode control block
`timescale 1ns/1ns
module counter_array_mode_ctrl_bench;
	import counter_array_pkg::*;

	logic                 clk;
	logic                 arst_n;
	logic [SFR_AW-1:0]    sfr_addr;
	logic                 sfr_wr;
	logic [SFR_DW-1:0]    sfr_wdata;
	logic [SFR_DW-1:0]    sfr_rdata;
	logic                 cpu_idle;
	logic                 timer0_ovf;
	logic                 ext_count;
	logic                 ext_clk;
	logic                 global_en;
	logic                 array_en;
	logic                 ovf_flag;
	logic [MODULES-1:0]   match_flag;
	logic                 count_tick;
	logic [MODULES*3-1:0] opmode;
	logic                 wd_active;
	logic                 wd_expire;
	logic                 irq_req;
	int                   fail_count;
	int                   n_tests;
	int                   seed;
	int                   ticks;
	logic [7:0]           d;
	logic [5:0]           ens;
	logic [5:0]           fl;
	logic                 ovf_en;
	logic                 ga;
	logic                 ae;
	logic                 of;
	logic [2:0]           srcs[3] = '{TB_TIMER0, TB_EXT_COUNT, TB_EXT_CLK_DIV8};
	int                   reps[3] = '{3, 5, 16};

	counter_array_mode_ctrl counter_array_mode_ctrl_i
	(
		.CLK(clk), .ARST_N(arst_n), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
		.SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .CPU_IDLE(cpu_idle),
		.TIMER0_OVF(timer0_ovf), .EXTERNAL_COUNT_INPUT(ext_count),
		.EXT_CLK(ext_clk), .GLOBAL_IRQ_ENABLE(global_en),
		.ARRAY_IRQ_ENABLE(array_en), .COUNTER_OVERFLOW_FLAG(ovf_flag),
		.MODULE_MATCH_FLAG(match_flag), .COUNT_TICK(count_tick),
		.MODULE_OPMODE(opmode), .WATCHDOG_ACTIVE(wd_active),
		.WATCHDOG_EXPIRE(wd_expire), .IRQ_REQ(irq_req)
	);

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		sfr_addr  <= a;
		sfr_wdata <= v;
		sfr_wr    <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask

	// read data is registered, so give the address two edges to land
	task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		sfr_addr <= a;
		repeat (2) @(posedge clk);
		#1;
		check(18'(sfr_rdata), 18'(exp));
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic count(input int n);
		ticks = 0;
		repeat (n)
		begin
			@(posedge clk);
			#1;
			ticks += int'(count_tick === 1'b1);
		end
	endtask

	// edges spaced five cycles apart keep the count pin under its rate limit
	task automatic wiggle(input int which, input int n);
		repeat (n)
		begin
			@(posedge clk);
			if (which == 0)
				timer0_ovf <= 1'b1;
			else if (which == 1)
				ext_count <= 1'b0;
			else
				ext_clk <= 1'b1;
			@(posedge clk);
			timer0_ovf <= 1'b0;
			ext_count  <= 1'b1;
			ext_clk    <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask

	function automatic logic [2:0] exp_opmode(input logic [7:0] v);
		return (v[3:1] == 3'h7) ? OPMODE_OFF : v[3:1];
	endfunction

	// idle external sources give no ticks, nor do the reserved codes
	function automatic int exp_ticks(input logic [2:0] sel, input int n);
		case (sel)
			TB_SYS_DIV12: return n / 12;
			TB_SYS_DIV4: return n / 4;
			TB_SYS: return n;
			default: return 0;
		endcase
	endfunction

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ************************************************************
	// clock, watchdog and main sequence
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		#200000;
		fail_count++;
		conclude();
	end

	initial
	begin
		{arst_n, sfr_wr, cpu_idle, timer0_ovf, ext_clk} = '0;
		{global_en, array_en, ovf_flag, match_flag} = '0;
		sfr_addr = '0;
		sfr_wdata = '0;
		ext_count = 1'b1;
		fail_count = 0;
		n_tests = 0;
		seed = 32'h38e6;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		settle();
		check(18'(wd_active), 18'h1);
		sfr_read(ADDR_ARRAY_MODE, ARRAY_MODE_RESET);
		sfr_write(ADDR_ARRAY_MODE, 8'hCA);
		sfr_read(ADDR_ARRAY_MODE, ARRAY_MODE_RESET);
		sfr_write(ADDR_ARRAY_MODE, 8'h00);
		sfr_read(ADDR_ARRAY_MODE, 8'h00);
		check(18'(wd_active), 18'h0);
		for (int i = 0; i < 8; i++)
		begin
			d = 8'($random(seed)) & 8'h9F;
			// reserved timebase codes are never programmed
			if (d[3:1] > TB_EXT_CLK_DIV8)
				d[3] = 1'b0;
			sfr_write(ADDR_ARRAY_MODE, d);
			sfr_read(ADDR_ARRAY_MODE, d & 8'h8F);
		end
		sfr_write(8'hD8, 8'hFF);
		sfr_read(8'hD8, 8'h00);
		for (int m = 0; m < MODULES; m++)
			for (int k = 0; k < 8; k++)
			begin
				d = {4'($random(seed)), 3'(k), 1'($random(seed))};
				sfr_write(ADDR_MODULE_BASE + 8'(m), d);
				sfr_read(ADDR_MODULE_BASE + 8'(m), d & MODULE_MODE_WMASK);
				check(18'(opmode[3*m +: 3]), 18'(exp_opmode(d)));
			end
		for (int i = 0; i < 32; i++)
		begin
			ens = 6'($random(seed));
			ovf_en = 1'($random(seed));
			fl = 6'($random(seed));
			of = 1'($random(seed));
			ga = (i < 20) | 1'($random(seed));
			ae = (i < 20) | 1'($random(seed));
			for (int m = 0; m < MODULES; m++)
				sfr_write(ADDR_MODULE_BASE + 8'(m), {7'h0, ens[m]});
			sfr_write(ADDR_ARRAY_MODE, {7'h0, ovf_en});
			@(posedge clk);
			{global_en, array_en, ovf_flag, match_flag} <= {ga, ae, of, fl};
			settle();
			check(18'(irq_req), 18'(ga & ae & (|(fl & ens) | (of & ovf_en))));
		end
		sfr_write(ADDR_ARRAY_MODE, 8'h01);
		@(posedge clk);
		{global_en, array_en, ovf_flag, match_flag} <= {3'b111, 6'h00};
		settle();
		check(18'(irq_req), 18'h1);
		sfr_write(ADDR_ARRAY_MODE, 8'h00);
		settle();
		check(18'(irq_req), 18'h0);
		// only the six defined timebase codes are used
		for (int s = 0; s < 6; s++)
		begin
			sfr_write(ADDR_ARRAY_MODE, {4'h0, 3'(s), 1'b0});
			repeat (6) @(posedge clk);
			count(48);
			check(18'(ticks), 18'(exp_ticks(3'(s), 48)));
		end
		for (int w = 0; w < 3; w++)
		begin
			sfr_write(ADDR_ARRAY_MODE, {4'h0, srcs[w], 1'b0});
			fork
				count(reps[w] * 5 + 20);
				wiggle(w, reps[w]);
			join
			check(18'(ticks), 18'(reps[w] / ((w == 2) ? 8 : 1)));
		end
		sfr_write(ADDR_ARRAY_MODE, {1'b1, 3'h0, TB_SYS, 1'b0});
		cpu_idle <= 1'b1;
		repeat (3) @(posedge clk);
		count(20);
		check(18'(ticks), 18'h0);
		sfr_write(ADDR_ARRAY_MODE, {4'h0, TB_SYS, 1'b0});
		repeat (3) @(posedge clk);
		count(20);
		check(18'(ticks), 18'h14);
		cpu_idle <= 1'b0;
		sfr_write(ADDR_ARRAY_MODE, 8'h60);
		sfr_write(ADDR_ARRAY_MODE, 8'h00);
		sfr_read(ADDR_ARRAY_MODE, 8'h60);
		check(18'(wd_active), 18'h1);
		sfr_write(ADDR_MODULE_BASE + 8'(WATCHDOG_MODULE), 8'h01);
		@(posedge clk);
		{global_en, array_en, ovf_flag, match_flag} <= {3'b110, 6'h20};
		settle();
		check(18'(wd_expire), 18'h1);
		check(18'(irq_req), 18'h0);
		match_flag <= '0;
		settle();
		check(18'(wd_expire), 18'h0);
		conclude();
	end
endmodule

//--- counter_array_pkg.sv
// constants shared by the counter array mode and timebase logic
package counter_array_pkg;

	localparam int SFR_AW = 8;
	localparam int SFR_DW = 8;
	localparam int MODULES = 6;
	localparam int MODE_W = 3;

	// ************************************************************
	// register addresses
	// ************************************************************
	localparam logic [7:0] ADDR_ARRAY_MODE = 8'hD9;
	localparam logic [7:0] ADDR_MODULE_BASE = 8'hDA;
	localparam logic [7:0] ADDR_MODULE_LAST = 8'hDF;

	// ************************************************************
	// counter_array_mode fields
	// ************************************************************
	localparam logic [7:0] ARRAY_MODE_RESET = 8'h40;
	localparam logic [7:0] ARRAY_MODE_WMASK = 8'hEF;
	localparam int IDLE_SUSPEND_BIT = 7;
	localparam int WATCHDOG_ENABLE_BIT = 6;
	localparam int WATCHDOG_LOCK_BIT = 5;
	localparam int TIMEBASE_LO = 1;
	localparam int OVERFLOW_IRQ_ENABLE_BIT = 0;

	// ************************************************************
	// module_mode_register fields
	// ************************************************************
	localparam logic [7:0] MODULE_MODE_RESET = 8'h00;
	localparam logic [7:0] MODULE_MODE_WMASK = 8'h0F;
	localparam int MODULE_MATCH_IRQ_ENABLE_BIT = 0;
	localparam int MODULE_FIELD_LO = 1;
	localparam int WATCHDOG_MODULE = 5;

	// operating mode codes, one per module
	localparam logic [2:0] OPMODE_OFF = 3'h0;
	localparam logic [2:0] OPMODE_CAPTURE = 3'h1;
	localparam logic [2:0] OPMODE_SW_TIMER = 3'h2;
	localparam logic [2:0] OPMODE_HS_OUTPUT = 3'h3;
	localparam logic [2:0] OPMODE_FREQ_OUT = 3'h4;
	localparam logic [2:0] OPMODE_PWM8 = 3'h5;
	localparam logic [2:0] OPMODE_PWM16 = 3'h6;

	// ************************************************************
	// timebase select codes and divide ratios
	// ************************************************************
	localparam logic [2:0] TB_SYS_DIV12 = 3'h0;
	localparam logic [2:0] TB_SYS_DIV4 = 3'h1;
	localparam logic [2:0] TB_TIMER0 = 3'h2;
	localparam logic [2:0] TB_EXT_COUNT = 3'h3;
	localparam logic [2:0] TB_SYS = 3'h4;
	localparam logic [2:0] TB_EXT_CLK_DIV8 = 3'h5;
	localparam logic [3:0] DIV12_LAST = 4'hB;
	localparam logic [3:0] DIV4_LAST = 4'h3;
	localparam logic [3:0] DIV8_LAST = 4'h7;

endpackage

//--- counter_array_timebase.sv
// timebase tick generator for the counter array
`timescale 1ns/1ns
module counter_array_timebase
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [2:0] sel,
	input  wire logic       timer0_ovf,
	input  wire logic       ext_count_in,
	input  wire logic       ext_clk,
	output logic            tick
);
	import counter_array_pkg::*;

	logic [3:0] div_cnt;
	logic [3:0] ext_cnt;
	logic [1:0] eci_sync;
	logic       eci_last;
	logic [1:0] clk_sync;
	logic       clk_last;
	logic       eci_fall;
	logic       clk_rise;
	logic [3:0] div_last;
	logic       next_tick;

	assign eci_fall = eci_last & ~eci_sync[1];
	assign clk_rise = ~clk_last & clk_sync[1];
	assign div_last = (sel == TB_SYS_DIV12) ? DIV12_LAST : DIV4_LAST;

	// ************************************************************
	// pin synchronisers, second stage feeds the edge detectors
	// ************************************************************
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			eci_sync <= 2'h3;
			eci_last <= 1'b1;
			clk_sync <= 2'h0;
			clk_last <= 1'b0;
		end
		else
		begin
			eci_sync <= {eci_sync[0], ext_count_in};
			eci_last <= eci_sync[1];
			clk_sync <= {clk_sync[0], ext_clk};
			clk_last <= clk_sync[1];
		end
	end

	// ************************************************************
	// prescalers
	// ************************************************************
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			div_cnt <= 4'h0;
		else if (div_cnt >= div_last)
			div_cnt <= 4'h0;
		else
			div_cnt <= div_cnt + 4'h1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ext_cnt <= 4'h0;
		else if (clk_rise)
			ext_cnt <= (ext_cnt == DIV8_LAST) ? 4'h0 : ext_cnt + 4'h1;
	end

	always_comb
	begin
		case (sel)
			TB_SYS_DIV12: next_tick = (div_cnt == DIV12_LAST);
			TB_SYS_DIV4: next_tick = (div_cnt >= DIV4_LAST);
			TB_TIMER0: next_tick = timer0_ovf;
			TB_EXT_COUNT: next_tick = eci_fall;
			TB_SYS: next_tick = 1'b1;
			TB_EXT_CLK_DIV8: next_tick = clk_rise && (ext_cnt == DIV8_LAST);
			// reserved codes simply stop the count
			default: next_tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tick <= 1'b0;
		else
			tick <= next_tick;
	end

endmodule
